// file: include/gtd_pkg.sv
// package for the satellite time display status block
package gtd_pkg;
  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ZONE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TIME = 8'h0C;
  localparam logic [7:0] ADDR_DATE = 8'h10;
  localparam logic [7:0] ADDR_DIGITS = 8'h14;
  localparam logic [7:0] ADDR_RAW_TIME = 8'h18;
  // ctrl fields
  localparam int CTRL_CONV_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_RXTYPE_BIT = 3;
  localparam int CTRL_LEGACY_BIT = 4;
  localparam int CTRL_DST_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ZONE_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // message format: ascii, stx then fixed fields then etx
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam int MSG_LEN = 16;
  // field positions inside message body
  localparam int POS_HOUR = 0;
  localparam int POS_MIN = 2;
  localparam int POS_SEC = 4;
  localparam int POS_DAY = 6;
  localparam int POS_MON = 8;
  localparam int POS_YEAR = 10;
  localparam int POS_DOW = 12;
  localparam int POS_SYNC = 13;
  localparam int POS_ZONE = 14;
  localparam int POS_ANN = 15;
  // status digit characters
  localparam logic [7:0] CH_DASH = 8'h2D;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_U_LOW = 8'h75;
  localparam logic [7:0] CH_D_LOW = 8'h64;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_L = 8'h4C;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_THREE = 8'h33;
  localparam logic [7:0] CH_SEVEN = 8'h37;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 250000000;
  localparam longint BAUD = 9600;
  localparam int BIT_CYC = int'(CLK_HZ / BAUD);
  localparam int LOSS_MS = 2000;
  localparam longint LOSS_CYC_L = CLK_HZ / 1000 * LOSS_MS;
  // display modes
  localparam logic [1:0] MODE_TIME = 2'h0;
  localparam logic [1:0] MODE_DATE = 2'h1;
  localparam logic [1:0] MODE_STAT = 2'h2;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } gtd_rx_t;
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } gtd_time_t;
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] mon;
    logic [4:0] day;
  } gtd_date_t;
  typedef struct packed {
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
    logic [7:0] d4;
    logic [7:0] d5;
    logic [7:0] d6;
  } gtd_digits_t;
endpackage

// file: logic/gtd_status.sv
// satellite time receiver decoder with local time conversion and status digits
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
// Contract
// - receiver sends message and pulse each second; device decodes time, date, status
// - pulse taken from cts line, or from general_input_one when the ctrl legacy bit is set
// - conversion enabled: universal time shifted to local zone plus seasonal hour
// - time mode shows raw time, or local time when conversion enabled
// - date mode shows raw date, or local date when conversion enabled
// - status mode shows a row of single character status digits
// - type one digit 3: 'A' data valid, 'u' not synchronised
// - digit 2: 'd' while messages arrive, dash otherwise
// - type two digit 3: dash, '1' synced no position, '3' synced positioned
// - type two digit 4: weekday 1 to 7, Monday is 1, else dash
// - type one digit 5: 'U' universal, 'S' summer time, dash standard
// - type one digit 6: 'A' season switch, 'L' leap second, dash none
module gtd_status #(
  parameter longint LOSS_CYC = gtd_pkg::LOSS_CYC_L,
  // bit time in clocks; a short value lets a whole message fit a short run
  parameter int BIT_CYC_P = gtd_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rxd,
  input wire logic cts,
  input wire logic general_input_one,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] disp_mode,
  output gtd_pkg::gtd_time_t disp_time,
  output gtd_pkg::gtd_date_t disp_date,
  output gtd_pkg::gtd_digits_t disp_digits
);
  import gtd_pkg::*;

  function automatic logic [6:0] dec2(input logic [7:0] hi, input logic [7:0] lo);
    logic [6:0] h;
    h = 7'(hi[3:0]) * 7'd10;
    dec2 = h + 7'(lo[3:0]);
  endfunction

  function automatic logic [4:0] mdays(input logic [3:0] m, input logic [6:0] y);
    case (m)
      4'h2: mdays = (y[1:0] == 2'h0) ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hB: mdays = 5'd30;
      default: mdays = 5'd31;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rxd_s, cts_s, gpi_s;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxd_s <= 2'b11;
      cts_s <= 2'b00;
      gpi_s <= 2'b00;
    end else begin
      rxd_s <= {rxd_s[0], rxd};
      cts_s <= {cts_s[0], cts};
      gpi_s <= {gpi_s[0], general_input_one};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl, zone;
  logic apb_wr;
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
      zone <= ZONE_RESET;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl <= pwdata;
    end else if (apb_wr && paddr == ADDR_ZONE) begin
      zone <= pwdata;
    end
  end
  logic conv_en, rx_type2, legacy, dst_on;
  logic signed [5:0] zone_hr;
  assign conv_en = ctrl[CTRL_CONV_BIT];
  assign disp_mode = ctrl[CTRL_MODE_LSB +: 2];
  assign rx_type2 = ctrl[CTRL_RXTYPE_BIT];
  assign legacy = ctrl[CTRL_LEGACY_BIT];
  assign dst_on = ctrl[CTRL_DST_BIT];
  assign zone_hr = zone[5:0];

  // ----------------------------------------------------------------
  // pulse detect and loss timers
  // ----------------------------------------------------------------
  logic pps_in, pps_d, pps_edge;
  assign pps_in = legacy ? gpi_s[1] : cts_s[1];
  assign pps_edge = pps_in && !pps_d;
  logic [31:0] pps_age, msg_age;
  logic pps_ok, msg_ok, msg_done;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pps_d <= 1'b0;
      pps_age <= 32'h0;
      pps_ok <= 1'b0;
    end else begin
      pps_d <= pps_in;
      if (pps_edge) begin
        pps_age <= 32'h0;
        pps_ok <= 1'b1;
      end else if (pps_age >= 32'(LOSS_CYC)) begin
        pps_ok <= 1'b0;
      end else begin
        pps_age <= pps_age + 32'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      msg_age <= 32'h0;
      msg_ok <= 1'b0;
    end else if (msg_done) begin
      msg_age <= 32'h0;
      msg_ok <= 1'b1;
    end else if (msg_age >= 32'(LOSS_CYC)) begin
      msg_ok <= 1'b0;
    end else begin
      msg_age <= msg_age + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // uart receiver, 8n1
  // ----------------------------------------------------------------
  gtd_rx_t rx_st;
  logic [15:0] bit_cnt;
  logic [2:0] bit_idx;
  logic [7:0] rx_sh;
  logic rx_vld;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_st <= RX_IDLE;
      bit_cnt <= 16'h0;
      bit_idx <= 3'h0;
      rx_sh <= 8'h0;
      rx_vld <= 1'b0;
    end else begin
      rx_vld <= 1'b0;
      case (rx_st)
        RX_IDLE: begin
          if (!rxd_s[1]) begin
            rx_st <= RX_START;
            bit_cnt <= 16'(BIT_CYC_P / 2);
          end
        end
        RX_START: begin
          if (bit_cnt == 16'h0) begin
            rx_st <= rxd_s[1] ? RX_IDLE : RX_DATA;
            bit_cnt <= 16'(BIT_CYC_P - 1);
            bit_idx <= 3'h0;
          end else begin
            bit_cnt <= bit_cnt - 16'h1;
          end
        end
        RX_DATA: begin
          if (bit_cnt == 16'h0) begin
            rx_sh <= {rxd_s[1], rx_sh[7:1]};
            bit_cnt <= 16'(BIT_CYC_P - 1);
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7) rx_st <= RX_STOP;
          end else begin
            bit_cnt <= bit_cnt - 16'h1;
          end
        end
        RX_STOP: begin
          if (bit_cnt == 16'h0) begin
            rx_st <= RX_IDLE;
            rx_vld <= rxd_s[1];
          end else begin
            bit_cnt <= bit_cnt - 16'h1;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // message assembly and decode
  // ----------------------------------------------------------------
  logic [7:0] msg [MSG_LEN];
  logic [4:0] msg_pos;
  logic in_msg;
  gtd_time_t raw_time;
  gtd_date_t raw_date;
  logic [7:0] dow_ch, sync_ch, zone_ch, ann_ch;
  assign msg_done = rx_vld && in_msg && rx_sh == CH_ETX && msg_pos == 5'(MSG_LEN);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      in_msg <= 1'b0;
      msg_pos <= 5'h0;
    end else if (rx_vld) begin
      if (rx_sh == CH_STX) begin
        in_msg <= 1'b1;
        msg_pos <= 5'h0;
      end else if (in_msg && msg_pos < 5'(MSG_LEN)) begin
        msg[msg_pos[3:0]] <= rx_sh;
        msg_pos <= msg_pos + 5'h1;
      end else begin
        in_msg <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      raw_time <= '0;
      raw_date <= '0;
      dow_ch <= CH_ZERO;
      sync_ch <= CH_ZERO;
      zone_ch <= CH_ZERO;
      ann_ch <= CH_ZERO;
    end else if (msg_done) begin
      raw_time.hour <= 5'(dec2(msg[POS_HOUR], msg[POS_HOUR + 1]));
      raw_time.min <= 6'(dec2(msg[POS_MIN], msg[POS_MIN + 1]));
      raw_time.sec <= 6'(dec2(msg[POS_SEC], msg[POS_SEC + 1]));
      raw_date.day <= 5'(dec2(msg[POS_DAY], msg[POS_DAY + 1]));
      raw_date.mon <= 4'(dec2(msg[POS_MON], msg[POS_MON + 1]));
      raw_date.year <= dec2(msg[POS_YEAR], msg[POS_YEAR + 1]);
      dow_ch <= msg[POS_DOW];
      sync_ch <= msg[POS_SYNC];
      zone_ch <= msg[POS_ZONE];
      ann_ch <= msg[POS_ANN];
    end
  end

  // ----------------------------------------------------------------
  // local time conversion, whole-hour zones only
  // ----------------------------------------------------------------
  gtd_time_t loc_time;
  gtd_date_t loc_date;
  always_comb begin
    logic signed [6:0] h;
    h = $signed({2'b00, raw_time.hour}) + 7'(zone_hr) + (dst_on ? 7'sd1 : 7'sd0);
    loc_time = raw_time;
    loc_date = raw_date;
    if (h >= 7'sd24) begin
      loc_time.hour = 5'(h - 7'sd24);
      if (raw_date.day >= mdays(raw_date.mon, raw_date.year)) begin
        loc_date.day = 5'd1;
        loc_date.mon = (raw_date.mon == 4'd12) ? 4'd1 : raw_date.mon + 4'd1;
        if (raw_date.mon == 4'd12) loc_date.year = raw_date.year + 7'd1;
      end else begin
        loc_date.day = raw_date.day + 5'd1;
      end
    end else if (h < 7'sd0) begin
      loc_time.hour = 5'(h + 7'sd24);
      if (raw_date.day <= 5'd1) begin
        loc_date.mon = (raw_date.mon <= 4'd1) ? 4'd12 : raw_date.mon - 4'd1;
        if (raw_date.mon <= 4'd1) loc_date.year = raw_date.year - 7'd1;
        loc_date.day = mdays(loc_date.mon, loc_date.year);
      end else begin
        loc_date.day = raw_date.day - 5'd1;
      end
    end else begin
      loc_time.hour = h[4:0];
    end
  end

  // ----------------------------------------------------------------
  // display outputs
  // ----------------------------------------------------------------
  gtd_digits_t next_digits;
  always_comb begin
    next_digits.d1 = pps_ok ? CH_P : CH_DASH;
    next_digits.d2 = msg_ok ? CH_D_LOW : CH_DASH;
    if (rx_type2) begin
      next_digits.d3 = (sync_ch == CH_ONE || sync_ch == CH_THREE) ? sync_ch : CH_DASH;
      next_digits.d4 = (dow_ch >= CH_ONE && dow_ch <= CH_SEVEN) ? dow_ch : CH_DASH;
      next_digits.d5 = CH_DASH;
      next_digits.d6 = CH_DASH;
    end else begin
      next_digits.d3 = (sync_ch == CH_A) ? CH_A : CH_U_LOW;
      next_digits.d4 = CH_DASH;
      next_digits.d5 = (zone_ch == CH_U || zone_ch == CH_S) ? zone_ch : CH_DASH;
      next_digits.d6 = (ann_ch == CH_A || ann_ch == CH_L) ? ann_ch : CH_DASH;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      disp_time <= '0;
      disp_date <= '0;
      disp_digits <= {6{CH_DASH}};
    end else begin
      disp_time <= (disp_mode == MODE_TIME) ? (conv_en ? loc_time : raw_time) : '0;
      disp_date <= (disp_mode == MODE_DATE) ? (conv_en ? loc_date : raw_date) : '0;
      disp_digits <= (disp_mode == MODE_STAT) ? next_digits : {6{CH_DASH}};
    end
  end

  // ----------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      ADDR_CTRL: prdata = ctrl;
      ADDR_ZONE: prdata = zone;
      ADDR_STATUS: prdata = {30'h0, msg_ok, pps_ok};
      ADDR_TIME: prdata = {15'h0, disp_time};
      ADDR_DATE: prdata = {16'h0, disp_date};
      ADDR_DIGITS: prdata = {disp_digits.d1, disp_digits.d2, disp_digits.d3, disp_digits.d4};
      ADDR_RAW_TIME: prdata = {15'h0, raw_time};
      default: begin
        prdata = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign pslverr = psel && penable && !rd_hit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pps_digit: assert property (@(posedge clk) disable iff (!resetn)
    disp_mode == MODE_STAT && $past(disp_mode) == MODE_STAT && $past(pps_ok)
      |-> disp_digits.d1 == CH_P) else $error("pulse digit wrong");
  a_msg_digit: assert property (@(posedge clk) disable iff (!resetn)
    disp_mode == MODE_STAT && $past(disp_mode) == MODE_STAT && !$past(msg_ok)
      |-> disp_digits.d2 == CH_DASH) else $error("serial digit wrong");
  a_msg_seen: assert property (@(posedge clk) disable iff (!resetn)
    msg_done |=> msg_ok) else $error("message not flagged");
  a_pps_seen: assert property (@(posedge clk) disable iff (!resetn)
    pps_edge |=> pps_ok) else $error("pulse not flagged");
  a_loss_pps: assert property (@(posedge clk) disable iff (!resetn)
    pps_ok && !pps_edge && pps_age >= 32'(LOSS_CYC) |=> !pps_ok) else $error("pulse loss missed");
  a_time_sel: assert property (@(posedge clk) disable iff (!resetn)
    disp_mode == MODE_TIME && !conv_en |=> disp_time == $past(raw_time) || $changed(ctrl))
    else $error("raw time not shown");
  a_date_sel: assert property (@(posedge clk) disable iff (!resetn)
    disp_mode == MODE_DATE && conv_en |=> disp_date == $past(loc_date) || $changed(ctrl))
    else $error("local date not shown");
  a_type1_d3: assert property (@(posedge clk) disable iff (!resetn)
    disp_mode == MODE_STAT && $past(disp_mode) == MODE_STAT && !$past(rx_type2)
      && $past(sync_ch) != CH_A |-> disp_digits.d3 == CH_U_LOW)
    else $error("valid digit wrong");
  a_type2_d4: assert property (@(posedge clk) disable iff (!resetn)
    disp_mode == MODE_STAT && $past(disp_mode) == MODE_STAT && $past(rx_type2)
      && ($past(dow_ch) < CH_ONE || $past(dow_ch) > CH_SEVEN) |-> disp_digits.d4 == CH_DASH)
    else $error("weekday digit wrong");
endmodule

// file: test/gtd_rx_model.sv
// model of the satellite time receiver: serial time messages and pulse outputs
`timescale 1ns/1ps
module gtd_rx_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk,
  input wire logic use_legacy,
  output logic rxd,
  output logic cts,
  output logic general_input_one
);
  logic locked;
  // ----------------------------------------------------------------
  // line levels
  // ----------------------------------------------------------------
  initial begin
    rxd = 1'b1;
    cts = 1'b0;
    general_input_one = 1'b0;
    locked = 1'b1;
  end
  // ----------------------------------------------------------------
  // one pulse-per-second edge on the wired pin
  // ----------------------------------------------------------------
  // no pulse while time is untrusted, so the pulse marks good time
  task automatic pulse();
    if (locked) begin
      @(posedge clk);
      if (use_legacy) begin
        general_input_one <= 1'b1;
      end else begin
        cts <= 1'b1;
      end
      repeat (4) @(posedge clk);
      cts <= 1'b0;
      general_input_one <= 1'b0;
    end
  endtask
  // ----------------------------------------------------------------
  // serial frames, 8n1, lsb first; caller enters just after an edge
  // ----------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
  // body holds the sixteen field characters, first character in the top byte
  task automatic send_msg(input logic [127:0] body);
    send_byte(8'h02);
    for (int i = 15; i >= 0; i--) begin
      send_byte(body[8*i +: 8]);
    end
    send_byte(8'h03);
  endtask
endmodule

// file: test/tb.sv
// self-checking testbench for the satellite time display status block
`timescale 1ns/1ps
module tb;
  import gtd_pkg::*;
  localparam longint LOSS = 2000;
  localparam int BIT = 16;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] disp_mode;
  gtd_time_t disp_time;
  gtd_date_t disp_date;
  gtd_digits_t digits;
  logic rxd;
  logic cts;
  logic gin;
  logic use_legacy = 1'b0;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] rdv;
  logic rerr;
  // ----------------------------------------------------------------
  // clock, parts
  // ----------------------------------------------------------------
  always #2 clk = ~clk;
  gtd_rx_model #(.BIT_CYC(BIT)) rcv (.clk(clk), .use_legacy(use_legacy), .rxd(rxd),
    .cts(cts), .general_input_one(gin));
  // short loss count and bit time keep each message and absence check short
  gtd_status #(.LOSS_CYC(LOSS), .BIT_CYC_P(BIT)) dut (.clk(clk), .resetn(resetn),
    .rxd(rxd), .cts(cts),
    .general_input_one(gin), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .disp_mode(disp_mode), .disp_time(disp_time),
    .disp_date(disp_date), .disp_digits(digits));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_regs();
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", {16'h0, CTRL_RESET}, {16'h0, rdv});
    apb(1'b0, ADDR_ZONE, 32'h0);
    chk("zone reset", {16'h0, ZONE_RESET}, {16'h0, rdv});
    chk("digits idle", {6{CH_DASH}}, digits);
    chk("time idle", 48'h0, {31'h0, disp_time});
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", 48'h1, {47'h0, rerr});
    chk("unmapped data", 48'h0, {16'h0, rdv});
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status read only", 48'h0, {16'h0, rdv});
    apb(1'b1, ADDR_ZONE, 32'h0000_003F);
    apb(1'b0, ADDR_ZONE, 32'h0);
    chk("zone write", 48'h3F, {42'h0, rdv[5:0]});
    apb(1'b1, ADDR_CTRL, 32'h0000_0021);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl write", 48'h21, {16'h0, rdv});
    chk("time mode", {46'h0, MODE_TIME}, {46'h0, disp_mode});
  endtask
  task automatic t_type_one();
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    cyc(3);
    chk("status mode", {46'h0, MODE_STAT}, {46'h0, disp_mode});
    chk("d1 no pulse", {40'h0, CH_DASH}, {40'h0, digits.d1});
    chk("d2 no serial", {40'h0, CH_DASH}, {40'h0, digits.d2});
    chk("d3 unsynced", {40'h0, CH_U_LOW}, {40'h0, digits.d3});
  endtask
  task automatic t_pulse();
    rcv.pulse();
    cyc(10);
    chk("d1 pulse", {40'h0, CH_P}, {40'h0, digits.d1});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status pulse", 48'h1, {47'h0, rdv[0]});
    cyc(int'(LOSS) - 200);
    chk("d1 held", {40'h0, CH_P}, {40'h0, digits.d1});
    cyc(400);
    chk("d1 lost", {40'h0, CH_DASH}, {40'h0, digits.d1});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status lost", 48'h0, {46'h0, rdv[1:0]});
  endtask
  task automatic t_type_two();
    apb(1'b1, ADDR_CTRL, 32'h0000_000C);
    cyc(3);
    chk("t2 d3", {40'h0, CH_DASH}, {40'h0, digits.d3});
    chk("t2 d4", {40'h0, CH_DASH}, {40'h0, digits.d4});
    chk("t2 d5 d6", {32'h0, CH_DASH, CH_DASH}, {32'h0, digits.d5, digits.d6});
  endtask
  task automatic t_msg_one();
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    rcv.send_msg("1234561503245ASL");
    cyc(3);
    chk("d2 serial", {40'h0, CH_D_LOW}, {40'h0, digits.d2});
    chk("d3 valid", {40'h0, CH_A}, {40'h0, digits.d3});
    chk("d5 summer", {40'h0, CH_S}, {40'h0, digits.d5});
    chk("d6 leap", {40'h0, CH_L}, {40'h0, digits.d6});
    apb(1'b0, ADDR_RAW_TIME, 32'h0);
    chk("raw time", {31'h0, 5'h0C, 6'h22, 6'h38}, {16'h0, rdv});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status serial", 48'h2, {46'h0, rdv[1:0]});
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    cyc(2);
    chk("raw time shown", {31'h0, 5'h0C, 6'h22, 6'h38}, {31'h0, disp_time});
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    cyc(2);
    chk("raw date shown", {32'h0, 7'h18, 4'h3, 5'h0F}, {32'h0, disp_date});
    apb(1'b1, ADDR_ZONE, 32'h0000_000D);
    apb(1'b1, ADDR_CTRL, 32'h0000_0023);
    cyc(2);
    chk("local date", {32'h0, 7'h18, 4'h3, 5'h10}, {32'h0, disp_date});
    apb(1'b1, ADDR_CTRL, 32'h0000_0021);
    cyc(2);
    chk("local time", {31'h0, 5'h02, 6'h22, 6'h38}, {31'h0, disp_time});
  endtask
  task automatic t_msg_two();
    apb(1'b1, ADDR_ZONE, 32'h0000_003F);
    apb(1'b1, ADDR_CTRL, 32'h0000_000C);
    rcv.send_msg("00300001032473--");
    cyc(3);
    chk("t2 synced", {40'h0, CH_THREE}, {40'h0, digits.d3});
    chk("t2 weekday", {40'h0, CH_SEVEN}, {40'h0, digits.d4});
    chk("t2 serial", {40'h0, CH_D_LOW}, {40'h0, digits.d2});
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    cyc(2);
    chk("date back", {32'h0, 7'h18, 4'h2, 5'h1D}, {32'h0, disp_date});
    apb(1'b1, ADDR_CTRL, 32'h0000_000C);
    cyc(2100);
    chk("t2 serial lost", {40'h0, CH_DASH}, {40'h0, digits.d2});
  endtask
  task automatic t_legacy();
    apb(1'b1, ADDR_CTRL, 32'h0000_0014);
    rcv.pulse();
    cyc(10);
    chk("legacy ignores cts", {40'h0, CH_DASH}, {40'h0, digits.d1});
    use_legacy <= 1'b1;
    rcv.pulse();
    cyc(10);
    chk("legacy pulse", {40'h0, CH_P}, {40'h0, digits.d1});
    apb(1'b1, ADDR_CTRL, 32'h0000_0012);
    cyc(3);
    chk("date mode", {46'h0, MODE_DATE}, {46'h0, disp_mode});
    chk("date digits", {6{CH_DASH}}, digits);
    chk("date idle", 48'h0, {32'h0, disp_date});
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    cyc(3);
    resetn <= 1'b1;
    t_reset_regs();
    t_type_one();
    t_pulse();
    t_type_two();
    t_legacy();
    t_msg_one();
    t_msg_two();
    give_verdict();
  end
  // about 10,000 cycles of tests; past 30,000 cycles it is a hang
  initial begin
    #120000;
    err_total++;
    give_verdict();
  end
endmodule
